// >>> design/rdc_pkg.sv
/*
 * constants for the redriver channel register bank: offsets, bases, fields,
 * reset values and detect-polling counts.
 * assumes a byte-wide register port driven by the serial-bus slave.
 */
// Contract
// R1 - status bits 7 and 6 latch termination sensed on positive and negative line
// R2 - channel offsets 0x00, 0x01, 0x03, 0x04, 0x05 and 0x0A are decoded
// R3 - boost bit 7 set bypasses first equalizer stage, reset zero
// R4 - boost bits 6..3 hold first-stage level, reset zero, forwarded
// R5 - boost bits 2..0 hold second-stage level, reset zero, forwarded
// R6 - offset 0x03 bits 6..3 hold midband profile; bit 7 reads zero
// R7 - offset 0x03 bits 2..0 hold flat gain, reset value 3'b101
// R8 - detect control bit 2 forces valid termination, bypassing the detect machine
// R9 - detect control bit 1 enables extra detect polling, reset zero
// R10 - extra polling needs 2 consecutive detects, or 3 when bit 0 set
// R11 - power override bit 7 lets register bits steer block power-down
// R12 - power-enable field switches blocks while overridden; resets all enabled
// R13 - detect reset bit 2 holds the detect machine in reset while set
// R14 - with detection disabled no termination sequencing is performed
// R15 - bank bases 0x00/0x20, 0x40/0x60 per channel; 0x80 broadcasts, reads channel 0
// R16 - each two-channel bank answers at its own bus target address
// R17 - reserved bits read zero; detect status clears on machine reset
package rdc_pkg;
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_BOOST   = 8'h01;
  localparam logic [7:0] OFS_PROFILE = 8'h03;
  localparam logic [7:0] OFS_DETCTL  = 8'h04;
  localparam logic [7:0] OFS_POWER   = 8'h05;
  localparam logic [7:0] OFS_DETRST  = 8'h0a;
  localparam logic [2:0] BASE_CH0A   = 3'h0;  // address bits 7:5
  localparam logic [2:0] BASE_CH0B   = 3'h1;
  localparam logic [2:0] BASE_CH1A   = 3'h2;
  localparam logic [2:0] BASE_CH1B   = 3'h3;
  localparam logic [2:0] BASE_BCAST  = 3'h4;
  localparam logic [4:0] OFS_MASK    = 5'h1f;
  localparam int         STS_P_BIT   = 7;
  localparam int         STS_N_BIT   = 6;
  localparam int         SKIP_BIT    = 7;
  localparam int         FORCE_BIT   = 2;
  localparam int         POLL_EN_BIT = 1;
  localparam int         POLL3_BIT   = 0;
  localparam int         OVR_BIT     = 7;
  localparam int         FSMRST_BIT  = 2;
  localparam logic [2:0] FLAT_RST    = 3'h5;
  localparam logic [6:0] PWR_EN_RST  = 7'h7f;
  localparam logic [1:0] POLLS_BASE  = 2'h1;
  localparam logic [1:0] POLLS_TWO   = 2'h2;
  localparam logic [1:0] POLLS_THREE = 2'h3;
endpackage : rdc_pkg

// >>> design/rdc_ctl_if.sv
/*
 * per-channel carrier between the register bank and the detect sequencer.
 * assumes one instance per channel, all in the bank clock domain.
 */
`timescale 1ns/1ps
interface rdc_ctl_if;
  logic       force_valid;
  logic       poll_en;
  logic       poll_three;
  logic       fsm_reset;
  logic [1:0] sense;
  logic [1:0] latched;
  modport regs (output force_valid, poll_en, poll_three, fsm_reset,
                input latched);
  modport seq  (input force_valid, poll_en, poll_three, fsm_reset, sense,
                output latched);
endinterface : rdc_ctl_if

// >>> design/rdc_detect_seq.sv
/*
 * termination-detect sequencer for one channel: counts consecutive valid
 * polls and latches positive/negative results.
 * assumes sense is a per-poll comparator result sampled on poll_tick.
 */
`timescale 1ns/1ps
module rdc_detect_seq
  import rdc_pkg::*;
(
  input  wire logic clock,     // bank clock
  input  wire logic rst_n,     // sync reset
  input  wire logic poll_tick, // one poll per pulse
  input  wire logic det_on,    // detection enabled
  rdc_ctl_if.seq    ctl        // control and results
);
  typedef enum logic [1:0] {RDC_IDLE, RDC_POLL, RDC_DONE} rdc_state_e;
  rdc_state_e state_q;
  logic [1:0] cnt_q;
  logic [1:0] need;
  logic [1:0] lat_q;
  logic       hit;

  assign need = !ctl.poll_en ? POLLS_BASE :
                (ctl.poll_three ? POLLS_THREE : POLLS_TWO); // R10
  assign hit  = &ctl.sense;
  assign ctl.latched = ctl.force_valid ? 2'h3 : lat_q; // R8

  always_ff @(posedge clock) begin
    if (!rst_n || ctl.fsm_reset || !det_on) begin // R13 R14 R17
      state_q <= RDC_IDLE;
      cnt_q   <= 2'h0;
      lat_q   <= 2'h0;
    end else if (poll_tick) begin
      case (state_q)
        RDC_IDLE: state_q <= RDC_POLL;
        RDC_POLL: begin
          // a miss restarts the run, so only consecutive hits count
          cnt_q <= hit ? cnt_q + 2'h1 : 2'h0; // R10
          if (hit && (cnt_q + 2'h1 >= need)) begin
            state_q <= RDC_DONE;
            lat_q   <= ctl.sense; // R1
          end
        end
        RDC_DONE: state_q <= RDC_DONE;
        default:  state_q <= RDC_IDLE;
      endcase
    end
  end

  a_latch_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == RDC_DONE && !ctl.fsm_reset && det_on) |=> // R1
      lat_q == $past(lat_q))
    else $error("latched detect result changed");
  a_reset_clears: assert property (@(posedge clock) disable iff (!rst_n)
    ctl.fsm_reset |=> lat_q == 2'h0) // R13
    else $error("detect reset did not clear status");
  a_poll_count: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(state_q == RDC_DONE) |-> // R10
      $past(hit) && ($past(cnt_q) + 2'h1 >= $past(need)))
    else $error("detect finished before enough polls");
  a_no_det_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !det_on |=> state_q == RDC_IDLE && lat_q == 2'h0) // R14
    else $error("sequencing active with detection off");
endmodule : rdc_detect_seq

// >>> design/rdc_bank.sv
/*
 * two-channel register bank of the redriver: decode, broadcast writes,
 * read mux, and per-channel equalizer/power outputs.
 * assumes the serial-bus slave presents one byte access per strobe, already
 * matched to this bank's own target address.
 */
`timescale 1ns/1ps
module rdc_bank
  import rdc_pkg::*;
(
  input  wire logic       clock,         // 50 MHz bank clock
  input  wire logic       rst_n,         // sync reset, active low
  input  wire logic       wr_stb,        // one-cycle write strobe
  input  wire logic       rd_stb,        // one-cycle read strobe
  input  wire logic [7:0] addr,          // register address
  input  wire logic [7:0] wdata,         // write data
  output logic      [7:0] rdata,         // read data, registered
  output logic            rvalid,        // read data valid pulse
  input  wire logic       det_on,        // receiver detection enabled
  input  wire logic       poll_tick,     // detect poll pulse
  input  wire logic [1:0] sense0,        // channel 0 p/n comparator
  input  wire logic [1:0] sense1,        // channel 1 p/n comparator
  output logic      [1:0] skip,          // first stage bypass per channel
  output logic      [7:0] first_level,   // 4 bits per channel
  output logic      [5:0] second_level,  // 3 bits per channel
  output logic      [7:0] midband_shape, // 4 bits per channel
  output logic      [5:0] flat_gain,     // 3 bits per channel
  output logic     [13:0] block_en,      // 7 block enables per channel
  output logic      [1:0] term_valid     // far-end termination valid
);
  //////////////////////////////////////////////////////////////////////////
  // R16: target-address matching is done by the serial-bus slave

  // decode of channel select; used by both write and read paths
  function automatic logic [1:0] ch_sel(input logic [7:0] a,
                                        input logic       is_wr);
    logic [1:0] s;
    s = 2'h0;
    case (a[7:5])
      BASE_CH0A, BASE_CH0B: s = 2'h1; // R15
      BASE_CH1A, BASE_CH1B: s = 2'h2; // R15
      BASE_BCAST:           s = is_wr ? 2'h3 : 2'h1; // R15
      default:              s = 2'h0;
    endcase
    return s;
  endfunction : ch_sel

  logic [1:0] wsel;
  logic [1:0] rsel;
  logic [4:0] ofs;
  assign wsel = wr_stb ? ch_sel(addr, 1'b1) : 2'h0;
  assign rsel = ch_sel(addr, 1'b0);
  assign ofs  = addr[4:0] & OFS_MASK;

  logic [7:0] boost_q   [2];
  logic [6:0] prof_q    [2];
  logic [2:0] detctl_q  [2];
  logic [7:0] power_q   [2];
  logic       fsmrst_q  [2];
  logic [7:0] rd_ch     [2];
  logic [1:0] latched   [2];

  //////////////////////////////////////////////////////////////////////////
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      rdc_ctl_if ctl ();
      logic hit_w;
      assign hit_w = wsel[c];

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          boost_q[c] <= 8'h00; // R3 R4 R5
        end else if (hit_w && ofs == OFS_BOOST[4:0]) begin
          boost_q[c] <= wdata; // R2 R3 R4 R5
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          prof_q[c] <= {4'h0, FLAT_RST}; // R6 R7
        end else if (hit_w && ofs == OFS_PROFILE[4:0]) begin
          prof_q[c] <= wdata[6:0]; // R6 R7
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          detctl_q[c] <= 3'h0; // R9
        end else if (hit_w && ofs == OFS_DETCTL[4:0]) begin
          detctl_q[c] <= wdata[2:0]; // R8 R9 R10
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          power_q[c] <= {1'b0, PWR_EN_RST}; // R11 R12
        end else if (hit_w && ofs == OFS_POWER[4:0]) begin
          power_q[c] <= wdata; // R11 R12
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          fsmrst_q[c] <= 1'b0;
        end else if (hit_w && ofs == OFS_DETRST[4:0]) begin
          fsmrst_q[c] <= wdata[FSMRST_BIT]; // R13
        end
      end

      assign ctl.force_valid = detctl_q[c][FORCE_BIT];   // R8
      assign ctl.poll_en     = detctl_q[c][POLL_EN_BIT]; // R9
      assign ctl.poll_three  = detctl_q[c][POLL3_BIT];   // R10
      assign ctl.fsm_reset   = fsmrst_q[c];              // R13
      assign ctl.sense       = (c == 0) ? sense0 : sense1;
      assign latched[c]      = ctl.latched;

      rdc_detect_seq u_seq (
        .clock     (clock),
        .rst_n     (rst_n),
        .poll_tick (poll_tick),
        .det_on    (det_on),
        .ctl       (ctl)
      );

      // reserved bits are forced to zero on the read path
      always_comb begin
        case (ofs)
          OFS_STATUS[4:0]:  rd_ch[c] = {latched[c], 6'h00}; // R1 R17
          OFS_BOOST[4:0]:   rd_ch[c] = boost_q[c];
          OFS_PROFILE[4:0]: rd_ch[c] = {1'b0, prof_q[c]}; // R6
          OFS_DETCTL[4:0]:  rd_ch[c] = {5'h00, detctl_q[c]}; // R17
          OFS_POWER[4:0]:   rd_ch[c] = power_q[c];
          OFS_DETRST[4:0]:  rd_ch[c] = {5'h00, fsmrst_q[c], 2'h0}; // R17
          default:          rd_ch[c] = 8'h00;
        endcase
      end

      assign skip[c]              = boost_q[c][SKIP_BIT]; // R3
      assign first_level[c*4+:4]  = boost_q[c][6:3];      // R4
      assign second_level[c*3+:3] = boost_q[c][2:0];      // R5
      assign midband_shape[c*4+:4] = prof_q[c][6:3];      // R6
      assign flat_gain[c*3+:3]    = prof_q[c][2:0];       // R7
      // without override the normal controls keep every block enabled
      assign block_en[c*7+:7]     = power_q[c][OVR_BIT] ?
                                    power_q[c][6:0] : PWR_EN_RST; // R11 R12
      // detection off makes the part a plain redriver: always terminated
      assign term_valid[c]        = !det_on || (&latched[c]); // R14 R8
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_stb;
      if (rd_stb) begin
        rdata <= rsel[0] ? rd_ch[0] : (rsel[1] ? rd_ch[1] : 8'h00); // R15
      end
    end
  end

  a_bcast_write: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_stb && addr == {BASE_BCAST, OFS_PROFILE[4:0]}) |=> // R15
      prof_q[0] == $past(wdata[6:0]) && prof_q[1] == $past(wdata[6:0]))
    else $error("broadcast write missed a channel");
  a_ch1_write: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_stb && addr[7:5] == BASE_CH1A && addr[4:0] == OFS_BOOST[4:0])
      |=> boost_q[1] == $past(wdata) && $stable(boost_q[0])) // R2
    else $error("channel 1 write misrouted");
  a_skip_out: assert property (@(posedge clock) disable iff (!rst_n)
    skip[0] == boost_q[0][7] && first_level[3:0] == boost_q[0][6:3]) // R3
    else $error("boost fields not forwarded");
  a_second_out: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_stb && addr == {BASE_CH0A, OFS_BOOST[4:0]}) |=>
      second_level[2:0] == $past(wdata[2:0])) // R5
    else $error("second stage level not forwarded");
  a_flat_reset: assert property (@(posedge clock)
    !rst_n |=> flat_gain == 6'h2d && midband_shape == 8'h00) // R7
    else $error("flat gain reset value wrong");
  a_power_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !power_q[1][7] |-> block_en[13:7] == 7'h7f) // R11
    else $error("power override active while disabled");
  a_power_ovr: assert property (@(posedge clock) disable iff (!rst_n)
    (wsel[0] && ofs == OFS_POWER[4:0] && wdata == 8'h80)
      |=> block_en[6:0] == 7'h00) // R12
    else $error("override did not disable blocks");
  a_bcast_read: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_stb && addr == {BASE_BCAST, OFS_PROFILE[4:0]}) |=> // R15
      rvalid && rdata == {1'b0, $past(prof_q[0])})
    else $error("broadcast read not from channel 0");
  a_force_valid: assert property (@(posedge clock) disable iff (!rst_n)
    detctl_q[0][2] |-> term_valid[0]) // R8
    else $error("forced detect not valid");
  a_status_rsvd: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_stb && addr[4:0] == OFS_STATUS[4:0]) |=> rdata[5:0] == 6'h00) // R17
    else $error("reserved status bits nonzero");
endmodule : rdc_bank

// >>> tb/rdc_host_model.sv
/*
 * host-side model of the bank's byte port: single write and read cycles.
 * assumes the serial-bus slave already matched this bank's target address.
 */
`timescale 1ns/1ps
module rdc_host_model (
  input  wire logic       clock,  // bank clock
  output logic            wr_stb, // write strobe
  output logic            rd_stb, // read strobe
  output logic      [7:0] addr,   // register address
  output logic      [7:0] wdata,  // write data
  input  wire logic [7:0] rdata,  // read data
  input  wire logic       rvalid  // read valid pulse
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr   = 8'h00;
    wdata  = 8'h00;
  end
  // one bank per target address: channels 2-3 never reach this port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
    // idle qualifiers flip so a stale address never looks valid
    addr   <= ~a;
    wdata  <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    addr   <= ~a;
    #1;
    v = rvalid;
    d = rdata;
  endtask : rd
  // restart detection: set the hold bit, then clear it
  task automatic fsm_restart(input logic [7:0] a);
    wr(a, 8'h04);
    wr(a, 8'h00);
  endtask : fsm_restart
endmodule : rdc_host_model

// >>> tb/rdc_bank_tb.sv
/*
 * self-checking bench for the two-channel register bank.
 * assumes the host model drives the byte port; bench drives detect inputs.
 */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
  n_fail++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module rdc_bank_tb
  import rdc_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        det_on = 1'b1;
  logic        poll_tick = 1'b0;
  logic [1:0]  sense0 = 2'h0;
  logic [1:0]  sense1 = 2'h0;
  logic        wr_stb, rd_stb, rvalid;
  logic [7:0]  addr, wdata, rdata, first_level, midband_shape;
  logic [1:0]  skip, term_valid;
  logic [5:0]  second_level, flat_gain;
  logic [13:0] block_en;
  logic [7:0]  sh [2][16];
  logic [7:0]  ofs [6] = '{OFS_STATUS, OFS_BOOST, OFS_PROFILE,
                           OFS_DETCTL, OFS_POWER, OFS_DETRST};
  int          n_fail = 0;
  int          n_tests = 0;
  always #10 clock = ~clock;
  rdc_bank u_dut (.clock(clock), .rst_n(rst_n), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .addr(addr), .wdata(wdata), .rdata(rdata),
    .rvalid(rvalid), .det_on(det_on), .poll_tick(poll_tick),
    .sense0(sense0), .sense1(sense1), .skip(skip),
    .first_level(first_level), .second_level(second_level),
    .midband_shape(midband_shape), .flat_gain(flat_gain),
    .block_en(block_en), .term_valid(term_valid));
  rdc_host_model u_host (.clock(clock), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] msk(input logic [7:0] o);
    case (o)
      8'h01, 8'h05: return 8'hff;
      8'h03:        return 8'h7f;
      8'h04:        return 8'h07;
      8'h0a:        return 8'h04;
      default:      return 8'h00;
    endcase
  endfunction : msk
  function automatic logic [6:0] pw_exp(input logic [7:0] p);
    return p[7] ? p[6:0] : 7'h7f;
  endfunction : pw_exp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    if (a[7:5] == 3'h4 || a[7:5] < 3'h2)
      sh[0][a[4:0]] = d & msk({3'h0, a[4:0]});
    if (a[7:5] == 3'h4 || a[7:5] inside {3'h2, 3'h3})
      sh[1][a[4:0]] = d & msk({3'h0, a[4:0]});
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask : rd_chk
  task automatic chk_outs();
    #1;
    for (int c = 0; c < 2; c++) begin
      `CHK("skip", sh[c][1][7], skip[c])
      `CHK("first", sh[c][1][6:3], first_level[c*4+:4])
      `CHK("second", sh[c][1][2:0], second_level[c*3+:3])
      `CHK("shape", sh[c][3][6:3], midband_shape[c*4+:4])
      `CHK("flat", sh[c][3][2:0], flat_gain[c*3+:3])
      `CHK("block_en", pw_exp(sh[c][5]), block_en[c*7+:7])
    end
  endtask : chk_outs
  task automatic tick(input logic [1:0] s);
    @(posedge clock);
    poll_tick <= 1'b1;
    sense0    <= s;
    sense1    <= s;
    @(posedge clock);
    poll_tick <= 1'b0;
    // comparators carry no meaning between polls
    sense0    <= ~s;
    sense1    <= ~s;
  endtask : tick
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 20);
    n_fail++;
    give_verdict();
  end
  initial begin
    logic [7:0] o;
    logic [7:0] d;
    logic       c, al;
    void'($urandom(32'h2109));
    for (int k = 0; k < 2; k++)
      for (int j = 0; j < 16; j++) sh[k][j] = 8'h00;
    sh[0][3] = 8'h05;
    sh[1][3] = 8'h05;
    sh[0][5] = 8'h7f;
    sh[1][5] = 8'h7f;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int j = 0; j < 6; j++) begin
      rd_chk(ofs[j], sh[0][ofs[j]]);
      rd_chk(8'h60 | ofs[j], sh[1][ofs[j]]);
    end
    chk_outs();
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      c  = 1'($urandom_range(1, 0));
      al = 1'($urandom_range(1, 0));
      o  = ofs[$urandom_range(5, 1)];
      d  = 8'($urandom);
      wr({1'b0, c, al, o[4:0]}, d);
      rd_chk({1'b0, c, ~al, o[4:0]}, sh[c][o]);
      rd_chk({1'b0, ~c, al, o[4:0]}, sh[~c][o]);
      chk_outs();
    end
    wr(8'h85, 8'h80);
    chk_outs();
    wr(8'h83, 8'h6e);
    wr(8'h43, 8'h11);
    rd_chk(8'h83, sh[0][3]);
    rd_chk(8'h23, 8'h6e);
    wr(8'ha1, 8'hff);
    wr(8'h02, 8'hff);
    rd_chk(8'ha1, 8'h00);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h01, sh[0][1]);
    chk_outs();
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      automatic int n = (k < 2) ? 1 : k;
      wr(8'h84, 8'(k) & 8'h03);
      u_host.fsm_restart(8'h8a);
      tick(2'b00);
      tick(2'b01);
      repeat (n - 1) tick(2'b11);
      rd_chk(8'h00, 8'h00);
      tick(2'b11);
      rd_chk(8'h00, 8'hc0);
      rd_chk(8'h40, 8'hc0);
      `CHK("term_valid", 2'b11, term_valid)
    end
    wr(8'h8a, 8'h04);
    tick(2'b00);
    repeat (3) tick(2'b11);
    rd_chk(8'h00, 8'h00);
    wr(8'h8a, 8'h00);
    wr(8'h44, 8'h04);
    #1;
    `CHK("term_valid", 2'b10, term_valid)
    rd_chk(8'h40, 8'hc0);
    @(posedge clock);
    det_on <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("term_valid", 2'b11, term_valid)
    repeat (4) tick(2'b11);
    rd_chk(8'h00, 8'h00);
    $display("test detect done");
    give_verdict();
  end
endmodule : rdc_bank_tb
